// ### src/dlp_power_ctrl.v
/*
 * DRAM power-state and termination control with AXI4-Lite registers.
 * Assumes command pins, cke, odt and reset_n synchronous to ref_clk_in.
 */
// Our own choices: the register offsets and register access over AXI4-Lite.
// Summary of operation
// - Refresh with CKE low enters self-refresh
// - DLL off in self-refresh, reset on exit
// - Self-refresh ignores all but CKE, reset
// - Internal refresh starts within tCKE
// - CKE low with NOP enters power-down
// - Banks open means active, else precharge
// - Receivers off after tCPDED expires
// - A12 picks slow or fast exit from precharge power-down
// - Reset low leaves power-down immediately
// - Nonzero mode bits 4:0 enable termination value
// - ODT pin gates termination, ignored in self-refresh
// - Refresh encoding: CS,RAS,CAS low, WE high
`timescale 1ns/100ps
`include "dlp_consts.vh"
module dlp_power_ctrl (
	input wire ref_clk_in, // 10 MHz clock
	input wire sys_rst_in, // Async reset, active high
	input wire [7:0] s_axi_awaddr_in, // Write address
	input wire s_axi_awvalid_in, // Write address valid
	output reg s_axi_awready_out, // Write address ready
	input wire [31:0] s_axi_wdata_in, // Write data
	input wire [3:0] s_axi_wstrb_in, // Write strobes
	input wire s_axi_wvalid_in, // Write data valid
	output reg s_axi_wready_out, // Write data ready
	output reg [1:0] s_axi_bresp_out, // Write response
	output reg s_axi_bvalid_out, // Write response valid
	input wire s_axi_bready_in, // Write response ready
	input wire [7:0] s_axi_araddr_in, // Read address
	input wire s_axi_arvalid_in, // Read address valid
	output reg s_axi_arready_out, // Read address ready
	output reg [31:0] s_axi_rdata_out, // Read data
	output reg [1:0] s_axi_rresp_out, // Read response
	output reg s_axi_rvalid_out, // Read data valid
	input wire s_axi_rready_in, // Read data ready
	input wire cke_in, // Clock enable pin
	input wire cs_n_in, // Chip select, active low
	input wire ras_n_in, // Row strobe, active low
	input wire cas_n_in, // Column strobe, active low
	input wire we_n_in, // Write enable, active low
	input wire odt_in, // Termination control pin
	input wire dram_rst_n_in, // Device reset pin, active low
	input wire banks_open_in, // Any bank open
	input wire busy_in, // Command still in progress
	output reg dll_en_out, // DLL enabled
	output reg dll_rst_out, // DLL reset pulse
	output reg int_ref_out, // Internal refresh pulse
	output reg rcv_en_out, // Command receivers enabled
	output reg term_en_out, // Termination switched on
	output reg [2:0] term_val_out, // Termination value code
	output reg [2:0] pwr_state_out // Power state
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [5:0] mode_bits;
	reg [15:0] t_cke, t_xs, t_xsdll, t_xp, t_xpdll, t_ckesr, t_cpded;
	reg [2:0] state;
	reg [2:0] next_state;
	reg sref_ref_pend;
	reg aw_held, w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire is_ref, is_nop;
	wire cke_done, cpded_done, exit_done, ckesr_done;
	reg [15:0] exit_limit;
	wire term_mode_on;
	wire start_enter, start_exit;

	dlp_cmd_decode u_dec (
		.cs_n_in(cs_n_in),
		.ras_n_in(ras_n_in),
		.cas_n_in(cas_n_in),
		.we_n_in(we_n_in),
		.is_ref_out(is_ref),
		.is_nop_out(is_nop)
	);

	// Timers for tCKE, tCPDED, exit period and tCKESR
	dlp_wait_cnt u_cke (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(start_enter | start_exit),
		.limit_in(t_cke),
		.done_out(cke_done)
	);
	dlp_wait_cnt u_cpded (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(start_enter),
		.limit_in(t_cpded),
		.done_out(cpded_done)
	);
	dlp_wait_cnt u_exit (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(start_exit),
		.limit_in(exit_limit),
		.done_out(exit_done)
	);
	dlp_wait_cnt u_ckesr (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(start_enter),
		.limit_in(t_ckesr),
		.done_out(ckesr_done)
	);

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	assign start_enter = (state == `DLP_ST_IDLE) && !cke_in && dram_rst_n_in
		&& (is_ref || is_nop);
	assign start_exit = (state == `DLP_ST_SREF || state == `DLP_ST_PPD
		|| state == `DLP_ST_APD) && cke_in && dram_rst_n_in;

	// Exit period: tXSDLL after self-refresh, tXPDLL after slow-exit power-down, tXP otherwise
	always @* begin
		if (state == `DLP_ST_SREF) begin
			exit_limit = t_xsdll;
		end else if (state == `DLP_ST_PPD && !mode_bits[`DLP_MODE_A12_BIT]) begin
			exit_limit = t_xpdll;
		end else begin
			exit_limit = t_xp;
		end
	end

	// Next state selection
	always @* begin
		next_state = state;
		case (state)
			`DLP_ST_IDLE: begin
				if (start_enter && is_ref) begin
					next_state = `DLP_ST_SREF;
				end else if (start_enter && banks_open_in) begin
					next_state = `DLP_ST_APD;
				end else if (start_enter) begin
					next_state = `DLP_ST_PPD;
				end
			end
			`DLP_ST_SREF: begin
				// Only CKE and the reset pin matter here; command pins are ignored
				if (start_exit) begin
					next_state = `DLP_ST_SRX;
				end
			end
			`DLP_ST_PPD, `DLP_ST_APD: begin
				if (start_exit && is_nop) begin
					next_state = `DLP_ST_PDX;
				end
			end
			`DLP_ST_SRX, `DLP_ST_PDX: begin
				if (exit_done) begin
					next_state = `DLP_ST_IDLE;
				end
			end
			default: begin
				next_state = `DLP_ST_IDLE;
			end
		endcase
	end

	// State register; device reset pin forces idle
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state <= `DLP_ST_IDLE;
		end else if (!dram_rst_n_in) begin
			state <= `DLP_ST_IDLE;
		end else if (busy_in && state == `DLP_ST_IDLE) begin
			state <= `DLP_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Device-side outputs
	// ------------------------------------------------------------
	assign term_mode_on = (mode_bits[2:0] != 3'h0) || (mode_bits[4:3] != 2'h0);

	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			dll_en_out <= 1'b1;
			dll_rst_out <= 1'b0;
			int_ref_out <= 1'b0;
			rcv_en_out <= 1'b1;
			term_en_out <= 1'b0;
			term_val_out <= 3'h0;
			pwr_state_out <= `DLP_ST_IDLE;
			sref_ref_pend <= 1'b0;
		end else begin
			pwr_state_out <= state;
			// DLL off in self-refresh and slow-exit power-down
			dll_en_out <= !(state == `DLP_ST_SREF)
				&& !(state == `DLP_ST_PPD && !mode_bits[`DLP_MODE_A12_BIT]);
			// DLL reset pulse on leaving self-refresh
			dll_rst_out <= (state == `DLP_ST_SREF) && start_exit;
			// One internal refresh inside tCKE of entry
			int_ref_out <= sref_ref_pend && state == `DLP_ST_SREF;
			sref_ref_pend <= (state == `DLP_ST_IDLE) && start_enter && is_ref;
			// Receivers off once tCPDED has passed in power-down or self-refresh
			rcv_en_out <= !((state == `DLP_ST_SREF || state == `DLP_ST_PPD
				|| state == `DLP_ST_APD) && cpded_done);
			// Termination follows pin and mode bits, off in self-refresh
			term_en_out <= odt_in && term_mode_on && state != `DLP_ST_SREF;
			term_val_out <= mode_bits[2:0] != 3'h0 ? mode_bits[2:0]
				: {1'b0, mode_bits[4:3]};
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= 2'h0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			mode_bits <= 6'h00;
			t_cke <= `DLP_RST_TCNT;
			t_xs <= `DLP_RST_TXS;
			t_xsdll <= `DLP_RST_TXSDLL;
			t_xp <= `DLP_RST_TCNT;
			t_xpdll <= `DLP_RST_TXS;
			t_ckesr <= `DLP_RST_TCKESR;
			t_cpded <= `DLP_RST_TCPDED;
		end else begin
			s_axi_awready_out <= !aw_held && !s_axi_awready_out && !s_axi_bvalid_out;
			s_axi_wready_out <= !w_held && !s_axi_wready_out && !s_axi_bvalid_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
			end
			if (aw_held && w_held && !s_axi_bvalid_out) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= 2'h0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				case (aw_addr)
					`DLP_REG_MODE: if (w_strb[0]) mode_bits <= w_data[5:0];
					`DLP_REG_TCKE: if (w_strb[0]) t_cke <= w_data[15:0];
					`DLP_REG_TXS: if (w_strb[0]) t_xs <= w_data[15:0];
					`DLP_REG_TXSDLL: if (w_strb[0]) t_xsdll <= w_data[15:0];
					`DLP_REG_TXP: if (w_strb[0]) t_xp <= w_data[15:0];
					`DLP_REG_TXPDLL: if (w_strb[0]) t_xpdll <= w_data[15:0];
					`DLP_REG_TCKESR: if (w_strb[0]) t_ckesr <= w_data[15:0];
					`DLP_REG_TCPDED: if (w_strb[0]) t_cpded <= w_data[15:0];
					default: s_axi_bresp_out <= 2'h2;
				endcase
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= 2'h0;
		end else begin
			s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out;
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rresp_out <= 2'h0;
				case (s_axi_araddr_in)
					`DLP_REG_MODE: s_axi_rdata_out <= {26'h0, mode_bits};
					`DLP_REG_STAT: s_axi_rdata_out <= {24'h0, ckesr_done, cke_done,
						dll_en_out, term_en_out, 1'b0, state};
					`DLP_REG_TCKE: s_axi_rdata_out <= {16'h0000, t_cke};
					`DLP_REG_TXS: s_axi_rdata_out <= {16'h0000, t_xs};
					`DLP_REG_TXSDLL: s_axi_rdata_out <= {16'h0000, t_xsdll};
					`DLP_REG_TXP: s_axi_rdata_out <= {16'h0000, t_xp};
					`DLP_REG_TXPDLL: s_axi_rdata_out <= {16'h0000, t_xpdll};
					`DLP_REG_TCKESR: s_axi_rdata_out <= {16'h0000, t_ckesr};
					`DLP_REG_TCPDED: s_axi_rdata_out <= {16'h0000, t_cpded};
					default: begin
						s_axi_rdata_out <= 32'h0000_0000;
						s_axi_rresp_out <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end
endmodule // dlp_power_ctrl

// ### pkg/dlp_consts.vh
/*
 * Constants for the DRAM low-power and termination control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DLP_CONSTS_VH
`define DLP_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define DLP_REG_CTRL 8'h00
`define DLP_REG_MODE 8'h04
`define DLP_REG_STAT 8'h08
`define DLP_REG_TCKE 8'h0C
`define DLP_REG_TXS 8'h10
`define DLP_REG_TXSDLL 8'h14
`define DLP_REG_TXP 8'h18
`define DLP_REG_TXPDLL 8'h1C
`define DLP_REG_TCKESR 8'h20
`define DLP_REG_TCPDED 8'h24

// ------------------------------------------------------------
// Mode register field positions
// ------------------------------------------------------------
`define DLP_MODE_NOM_LSB 0
`define DLP_MODE_WR_LSB 3
`define DLP_MODE_A12_BIT 5

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DLP_RST_CTRL 32'h0000_0000
`define DLP_RST_MODE 32'h0000_0000
`define DLP_RST_TCNT 16'h0004
`define DLP_RST_TXS 16'h0010
`define DLP_RST_TXSDLL 16'h0200
`define DLP_RST_TCKESR 16'h0005
`define DLP_RST_TCPDED 16'h0001

// ------------------------------------------------------------
// Power states
// ------------------------------------------------------------
`define DLP_ST_IDLE 3'h0
`define DLP_ST_SREF 3'h1
`define DLP_ST_SRX 3'h2
`define DLP_ST_PPD 3'h3
`define DLP_ST_APD 3'h4
`define DLP_ST_PDX 3'h5

`endif

// ### src/dlp_cmd_decode.v
/*
 * Command decoder: classifies the registered command pins.
 * Assumes pins are already synchronous to ref_clk_in.
 */
`timescale 1ns/100ps
module dlp_cmd_decode (
	input wire cs_n_in, // Chip select, active low
	input wire ras_n_in, // Row strobe, active low
	input wire cas_n_in, // Column strobe, active low
	input wire we_n_in, // Write enable, active low
	output wire is_ref_out, // Refresh encoding
	output wire is_nop_out // NOP or deselect
);
	// Refresh: select, row, column low, write high
	assign is_ref_out = !cs_n_in && !ras_n_in && !cas_n_in && we_n_in;
	// Deselect or NOP encoding
	assign is_nop_out = cs_n_in || (ras_n_in && cas_n_in && we_n_in);
endmodule // dlp_cmd_decode

// ### src/dlp_wait_cnt.v
/*
 * Programmable down counter for one waiting period.
 * Assumes threshold is stable while counting.
 */
`timescale 1ns/100ps
module dlp_wait_cnt (
	input wire ref_clk_in, // Clock
	input wire sys_rst_in, // Async reset, active high
	input wire start_in, // Load threshold
	input wire [15:0] limit_in, // Threshold in cycles
	output wire done_out // Period elapsed
);
	reg [15:0] count;
	// Load on start, count down to zero
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count <= 16'h0000;
		end else if (start_in) begin
			count <= limit_in;
		end else if (count != 16'h0000) begin
			count <= count - 16'h0001;
		end
	end
	assign done_out = (count == 16'h0000) && !start_in;
endmodule // dlp_wait_cnt

// ### dv/dlp_power_sva.sv
/* Checker for the power-state and termination ports of dlp_power_ctrl.
   Assumes a bind by port name and a single clock domain. */
`timescale 1ns/100ps
module dlp_power_sva (
	input wire ref_clk_in, // Clock
	input wire sys_rst_in, // Reset, active high
	input wire cke_in, // Clock enable pin
	input wire cs_n_in, // Chip select
	input wire ras_n_in, // Row strobe
	input wire cas_n_in, // Column strobe
	input wire we_n_in, // Write enable
	input wire odt_in, // Termination pin
	input wire dram_rst_n_in, // Device reset pin
	input wire banks_open_in, // Any bank open
	input wire busy_in, // Command in progress
	input wire dll_en_out, // DLL on
	input wire dll_rst_out, // DLL reset pulse
	input wire int_ref_out, // Internal refresh
	input wire rcv_en_out, // Receivers on
	input wire term_en_out, // Termination on
	input wire [2:0] term_val_out, // Termination code
	input wire [2:0] pwr_state_out // Power state
);
// ----------------------------------------
// Sequences and properties
// ----------------------------------------
default clocking @(posedge ref_clk_in); endclocking
default disable iff (sys_rst_in);
// Idle block seeing a fresh CKE fall
sequence idle_go;
	$past(cke_in) && pwr_state_out == 3'h0 && !cke_in && !busy_in && dram_rst_n_in;
endsequence
sequence sr_enter;
	pwr_state_out != 3'h1 ##1 pwr_state_out == 3'h1;
endsequence
sequence sr_exit;
	pwr_state_out == 3'h1 ##1 pwr_state_out == 3'h2;
endsequence
// Refresh encoding on the command pins
sequence ref_cmd;
	!cs_n_in && !ras_n_in && !cas_n_in && we_n_in;
endsequence
a_sref_entry: assert property (idle_go ##0 ref_cmd
	|-> ##[1:3] pwr_state_out == 3'h1) else $error("self-refresh not entered");
a_pd_entry: assert property (idle_go ##0 cs_n_in
	|-> ##[1:3] pwr_state_out == (banks_open_in ? 3'h4 : 3'h3)) else $error("bad power-down");
a_dll_off_sref: assert property (pwr_state_out == 3'h1 |-> !dll_en_out)
	else $error("DLL on in self-refresh");
a_dll_rst_exit: assert property (sr_exit |-> $past(dll_rst_out)
	|| $past(dll_rst_out, 2)) else $error("no DLL reset at exit");
a_dll_on_exit: assert property (sr_exit |-> ##[0:2] dll_en_out)
	else $error("DLL not back on");
a_int_ref: assert property (sr_enter |-> ##[0:2] int_ref_out)
	else $error("no internal refresh");
a_rcv_off: assert property (pwr_state_out == 3'h3 [*4] |-> !rcv_en_out)
	else $error("receivers still on");
a_apd_dll: assert property (pwr_state_out == 3'h4 |-> dll_en_out)
	else $error("DLL off in active power-down");
a_pd_reset: assert property (!dram_rst_n_in && pwr_state_out inside {3'h3, 3'h4}
	|-> ##[1:2] pwr_state_out == 3'h0) else $error("reset pin ignored");
a_term_pin: assert property (!odt_in [*2] |-> ##1 !term_en_out)
	else $error("termination on with pin low");
a_term_sref: assert property (pwr_state_out == 3'h1 [*2] |-> !term_en_out)
	else $error("termination on in self-refresh");
a_term_val: assert property (term_en_out |-> term_val_out != 3'h0)
	else $error("termination on with zero code");
endmodule // dlp_power_sva

// ### dv/dlp_ctrl_model.sv
/* Memory controller model driving CKE, command pins and ODT.
   Assumes op_in changes just after a clock edge. */
`timescale 1ns/100ps
module dlp_ctrl_model (
	input wire ref_clk_in, // Clock
	input wire [1:0] op_in, // 0 run, 1 self-refresh, 2 power-down
	input wire odt_req_in, // Termination request
	output logic cke_out = 1'h1, // Clock enable pin
	output logic cs_n_out = 1'h1, // Chip select, active low
	output logic ras_n_out = 1'h1, // Row strobe, active low
	output logic cas_n_out = 1'h1, // Column strobe, active low
	output logic we_n_out = 1'h1, // Write enable, active low
	output logic odt_out = 1'h0 // Termination pin
);
logic [1:0] last_op = 2'h0;
// Refresh encoding on the first low-CKE cycle of self-refresh only, deselect otherwise
always @(posedge ref_clk_in) begin
	last_op <= op_in;
	cke_out <= op_in == 2'h0;
	cs_n_out <= !(op_in == 2'h1 && last_op != 2'h1);
	ras_n_out <= !(op_in == 2'h1 && last_op != 2'h1);
	cas_n_out <= !(op_in == 2'h1 && last_op != 2'h1);
	we_n_out <= 1'h1;
	odt_out <= odt_req_in;
end
endmodule // dlp_ctrl_model

// ### dv/test_dram_low_power_and_termination_control.sv
/* Testbench for dlp_power_ctrl: AXI4-Lite tasks and power-state scenarios.
   Assumes dlp_ctrl_model on the pin side and the checker bound below. */
`timescale 1ns/100ps
bind dlp_power_ctrl dlp_power_sva chk_u (.*);
module test_dram_low_power_and_termination_control;
logic ref_clk_in = 1'h0, sys_rst_in = 1'h1, s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
logic [31:0] s_axi_wdata_in = 32'h0;
logic [3:0] s_axi_wstrb_in = 4'hf;
logic dram_rst_n_in = 1'h1, banks_open_in = 1'h0, busy_in = 1'h0, odt_req = 1'h0;
logic [1:0] op = 2'h0;
wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
wire cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, odt_in;
wire dll_en_out, dll_rst_out, int_ref_out, rcv_en_out, term_en_out;
wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
wire [31:0] s_axi_rdata_out;
wire [2:0] term_val_out, pwr_state_out;
int bad_count = 0;
int check_count = 0;
logic [7:0] reg_at [8] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
logic [31:0] reg_rv [8] = '{32'h0, 32'h4, 32'h10, 32'h200, 32'h4, 32'h10, 32'h5, 32'h1};
dlp_power_ctrl dut_u (.*);
dlp_ctrl_model ctl_u (.ref_clk_in, .op_in(op), .odt_req_in(odt_req), .cke_out(cke_in),
	.cs_n_out(cs_n_in), .ras_n_out(ras_n_in), .cas_n_out(cas_n_in), .we_n_out(we_n_in),
	.odt_out(odt_in));
// 10 MHz clock
always #50 ref_clk_in = ~ref_clk_in;
// ----------------------------------------
// Tasks
// ----------------------------------------
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	check_count++;
	if (got !== exp) begin
		bad_count++;
		$display("Error %0t got %h want %h", $time, got, exp);
	end
endtask
task automatic summarize;
	$display("checks %0d errors %0d", check_count, bad_count);
	if (bad_count == 0 && check_count > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
task automatic tout;
	bad_count++;
	$display("Error %0t wait ran out", $time);
	summarize;
endtask
task automatic tick(input int n);
	repeat (n) @(posedge ref_clk_in);
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
	int n;
	@(posedge ref_clk_in);
	s_axi_awaddr_in <= a;
	s_axi_wdata_in <= d;
	s_axi_awvalid_in <= 1'h1;
	s_axi_wvalid_in <= 1'h1;
	s_axi_bready_in <= 1'h1;
	for (n = 0; n < 50; n++) begin
		@(posedge ref_clk_in);
		if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
		if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
		if (s_axi_bvalid_out) break;
	end
	if (n == 50) tout;
	s_axi_bready_in <= 1'h0;
	chk({30'h0, s_axi_bresp_out}, {30'h0, er});
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
	int n;
	@(posedge ref_clk_in);
	s_axi_araddr_in <= a;
	s_axi_arvalid_in <= 1'h1;
	s_axi_rready_in <= 1'h1;
	for (n = 0; n < 50; n++) begin
		@(posedge ref_clk_in);
		if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
		if (s_axi_rvalid_out) break;
	end
	if (n == 50) tout;
	s_axi_rready_in <= 1'h0;
	chk({30'h0, s_axi_rresp_out}, {30'h0, er});
	if (er == 2'h0) chk(s_axi_rdata_out, d);
endtask
task automatic wait_st(input logic [2:0] s);
	int n;
	for (n = 0; n < 300; n++) begin
		@(posedge ref_clk_in);
		if (pwr_state_out === s) break;
	end
	if (n == 300) tout;
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
initial begin
	tick(10);
	sys_rst_in <= 1'h0;
	for (int i = 0; i < 8; i++) rd(reg_at[i], reg_rv[i], 2'h0);
	// Status at idle: both timers done, DLL on, state idle
	rd(8'h08, 32'hE0, 2'h0);
	rd(8'h00, 32'h0, 2'h2);
	wr(8'h00, 32'h1, 2'h2);
	wr(8'h14, 32'h8, 2'h0);
	rd(8'h14, 32'h8, 2'h0);
	// Byte lane 0 off: the write is answered but must not land
	s_axi_wstrb_in <= 4'h0;
	wr(8'h14, 32'h9, 2'h0);
	s_axi_wstrb_in <= 4'hf;
	rd(8'h14, 32'h8, 2'h0);
	// Self-refresh, ODT raised while inside
	wr(8'h04, 32'h1, 2'h0);
	op <= 2'h1;
	wait_st(3'h1);
	tick(3);
	odt_req <= 1'h1;
	tick(20);
	chk({31'h0, dll_en_out}, 32'h0);
	chk({31'h0, term_en_out}, 32'h0);
	chk({31'h0, rcv_en_out}, 32'h0);
	// Status in self-refresh: timers done, DLL off, state 1
	rd(8'h08, 32'hC1, 2'h0);
	odt_req <= 1'h0;
	op <= 2'h0;
	wait_st(3'h2);
	wait_st(3'h0);
	chk({31'h0, dll_en_out}, 32'h1);
	// Slow, fast and active power-down
	for (int k = 0; k < 3; k++) begin
		wr(8'h04, (k == 1) ? 32'h20 : 32'h0, 2'h0);
		banks_open_in <= k == 2;
		op <= 2'h2;
		wait_st((k == 2) ? 3'h4 : 3'h3);
		tick(4);
		chk({31'h0, dll_en_out}, {31'h0, k != 0});
		chk({31'h0, rcv_en_out}, 32'h0);
		op <= 2'h0;
		wait_st(3'h5);
		wait_st(3'h0);
	end
	// Device reset pin inside power-down
	banks_open_in <= 1'h0;
	op <= 2'h2;
	wait_st(3'h3);
	dram_rst_n_in <= 1'h0;
	tick(3);
	chk({29'h0, pwr_state_out}, 32'h0);
	op <= 2'h0;
	tick(3);
	dram_rst_n_in <= 1'h1;
	// Entry held off while a command is in progress
	busy_in <= 1'h1;
	op <= 2'h2;
	tick(6);
	chk({29'h0, pwr_state_out}, 32'h0);
	op <= 2'h0;
	tick(3);
	busy_in <= 1'h0;
	// Termination truth table
	wr(8'h04, 32'h1, 2'h0);
	odt_req <= 1'h1;
	tick(4);
	chk({31'h0, term_en_out}, 32'h1);
	chk({29'h0, term_val_out}, 32'h1);
	wr(8'h04, 32'h10, 2'h0);
	tick(2);
	chk({29'h0, term_val_out}, 32'h2);
	wr(8'h04, 32'h0, 2'h0);
	tick(2);
	chk({31'h0, term_en_out}, 32'h0);
	odt_req <= 1'h0;
	// Mode enabled but pin low: termination stays off
	wr(8'h04, 32'h1, 2'h0);
	tick(3);
	chk({31'h0, term_en_out}, 32'h0);
	summarize;
end
endmodule // test_dram_low_power_and_termination_control
